// *** hdl/irg_glue.sv ***
// interrupt request glue: decode, strobes, latches and priority control
`timescale 1ns/1ps
// Contract
// - controller selected only inside the two-byte window at E0000-E0001.
// - first decode stage needs io_mem low and top three address bits high.
// - select goes low only with stage two enabled and bits 6, 5 low.
// - access qualifier sets at ale trailing edge on either low decode output.
// - write strobe low only with host write low and qualifier set.
// - read strobe low only with host read low and qualifier set.
// - latched address bit 0 drives register select; low write is init word.
// - second flop sets on phase 2; with phase 2 and tap high latch enables.
// - latch enable with ale low makes the strobe moving buffered data across.
// - controller is sole master; master select high, cascade unused.
// - each request is taken on its rising edge, not its level.
// - keyboard active-low request is inverted onto input 6, asynchronous.
// - interrupt raised only for the lowest-numbered unmasked pending request.
// - controller interrupt output goes straight to the processor input.
// - two acknowledge cycles; type byte driven during the second.
// - simultaneous requests held; highest served first, next afterwards.
// - input 3 is the or of all adapter requests; software polls them.
// - acknowledge clears the second flop, disabling the decode.
module irg_glue #(
  parameter int unsigned NUM_PAR = irg_pkg::NUM_PAR
) (
  // clock, reset, enable
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // host bus pins
  input wire logic [19:0] addr_i,
  input wire logic io_mem_i,
  input wire logic ale_i,
  input wire logic wr_n_i,
  input wire logic rd_n_i,
  input wire logic interrupt_acknowledge_n_i,
  input wire logic phase2_i,
  input wire logic divider_tap_b_i,
  input wire logic [7:0] buffered_data_i,
  // peripheral requests
  input wire logic disk_sync_request_i,
  input wire logic serial_request_a_i,
  input wire logic timer_request_i,
  input wire logic [NUM_PAR-1:0] parallel_request_i,
  input wire logic expansion4_request_i,
  input wire logic expansion5_request_i,
  input wire logic keyboard_request_n_i,
  input wire logic video_request_i,
  // controller side strobes and data
  output logic controller_select_n_o,
  output logic ctrl_write_strobe_n_o,
  output logic ctrl_read_strobe_n_o,
  output logic io_latch_enable_n_o,
  output logic data_latch_strobe_o,
  output logic register_select_bit_o,
  output logic master_slave_select_o,
  output logic [7:0] controller_data_o,
  output logic [7:0] read_data_o,
  // interrupt path to the processor
  output logic processor_irq_input_o,
  output logic [7:0] type_byte_o,
  output logic type_byte_drive_o,
  output logic [7:0] pending_request_register_o
);
  irg_pkg::irg_host_type host_i;
  irg_pkg::irg_req_type req_i;
  irg_pkg::irg_host_type hm_q, h, hp;
  irg_pkg::irg_req_type rm_q, rs_q, rp_q;
  irg_pkg::irg_ack_type ack_q;
  logic [7:0] req_now, req_prev, req_rise, active, ack_clr;
  logic [7:0] pend_q, mask_q, data_q, type_q, rdata_q;
  logic [4:0] base_q;
  logic [2:0] sel_idx_q, pick_idx;
  logic qual1_q, qual2_q, init_q, rsel_q, irq_q, drive_q;
  logic sel_n_q, wr_n_q, rd_n_q, iol_n_q, dls_q, msel_q;
  logic stage1_en, dec_y0, dec_y1, win_hit, ale_fall, ale_rise;
  logic p2_rise, interrupt_acknowledge_n_fall, interrupt_acknowledge_n_rise, wr_act, rd_act;
  logic io_latch_act, data_latch_strobe_act, wr_end, pick_any;

  assign host_i = {addr_i, io_mem_i, ale_i, wr_n_i, rd_n_i,
                   interrupt_acknowledge_n_i, phase2_i,
                   divider_tap_b_i, buffered_data_i};
  // keyboard kept active low here, inverted after sync; adapters or'd onto input 3
  assign req_i = {video_request_i, keyboard_request_n_i,
                  expansion5_request_i, expansion4_request_i,
                  |parallel_request_i, timer_request_i,
                  serial_request_a_i, disk_sync_request_i};

  // two-flop synchronisers plus an edge stage; reset to idle, no false edge
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      hm_q <= irg_pkg::HOST_IDLE;
      h <= irg_pkg::HOST_IDLE;
      hp <= irg_pkg::HOST_IDLE;
      rm_q <= irg_pkg::REQ_IDLE;
      rs_q <= irg_pkg::REQ_IDLE;
      rp_q <= irg_pkg::REQ_IDLE;
    end else if (ce_i) begin
      hm_q <= host_i;
      h <= hm_q;
      hp <= h;
      rm_q <= req_i;
      rs_q <= rm_q;
      rp_q <= rs_q;
    end
  end

  // decode in two stages, then the low select bits
  assign stage1_en = ~h.io_mem
                     & (h.addr[19:17] == irg_pkg::STAGE1_TOP);
  assign dec_y0 = stage1_en & (h.addr[16:15] == irg_pkg::STAGE2_Y0);
  assign dec_y1 = stage1_en & (h.addr[16:15] == irg_pkg::STAGE2_Y1);
  // full compare keeps aliases out of the two-byte window
  assign win_hit = dec_y0
                   & (h.addr[6:5] == irg_pkg::LOW_SEL_BITS)
                   & (h.addr[19:1] == irg_pkg::CTRL_WIN_WORD);
  assign ale_fall = hp.ale & ~h.ale;
  assign ale_rise = ~hp.ale & h.ale;
  assign p2_rise = ~hp.phase2 & h.phase2;
  assign interrupt_acknowledge_n_fall = hp.interrupt_acknowledge_n_n & ~h.interrupt_acknowledge_n_n;
  assign interrupt_acknowledge_n_rise = ~hp.interrupt_acknowledge_n_n & h.interrupt_acknowledge_n_n;
  assign wr_act = ~h.wr_n & qual1_q;
  assign rd_act = ~h.rd_n & qual1_q;
  assign io_latch_act = qual2_q & h.phase2 & h.tap_b;
  // data moves while the address strobe is idle
  assign data_latch_strobe_act = io_latch_act & ~h.ale;
  assign wr_end = ~wr_n_q & ~wr_act & ~sel_n_q;

  // access qualifier: armed at ale trailing edge, dropped at next ale leading edge
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      qual1_q <= 1'b0;
    end else if (ce_i) begin
      if (ale_fall && (dec_y0 || dec_y1)) begin
        qual1_q <= 1'b1;
      end else if (ale_rise) begin
        qual1_q <= 1'b0;
      end
    end
  end

  // second qualifier follows on phase 2; acknowledge forces it off
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      qual2_q <= 1'b0;
    end else if (ce_i) begin
      if (!h.interrupt_acknowledge_n_n || !qual1_q) begin
        qual2_q <= 1'b0;
      end else if (p2_rise) begin
        qual2_q <= 1'b1;
      end
    end
  end

  // registered strobes, all pin outputs come from flops
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sel_n_q <= 1'b1;
      wr_n_q <= 1'b1;
      rd_n_q <= 1'b1;
      iol_n_q <= 1'b1;
      dls_q <= 1'b0;
      msel_q <= 1'b1;
    end else if (ce_i) begin
      sel_n_q <= ~(win_hit & qual2_q);
      wr_n_q <= ~wr_act;
      rd_n_q <= ~rd_act;
      iol_n_q <= ~io_latch_act;
      dls_q <= data_latch_strobe_act;
      msel_q <= 1'b1;
    end
  end

  // register select and data latch toward the controller
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rsel_q <= 1'b0;
      data_q <= irg_pkg::BYTE_RST;
    end else if (ce_i) begin
      if (ale_fall) begin
        rsel_q <= h.addr[0];
      end
      if (data_latch_strobe_act) begin
        data_q <= h.bd;
      end
    end
  end

  // controller registers: init word on select low, else mask
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      base_q <= irg_pkg::BASE_RST;
      mask_q <= irg_pkg::MASK_RST;
      init_q <= 1'b0;
      rdata_q <= irg_pkg::BYTE_RST;
    end else if (ce_i) begin
      if (wr_end && !rsel_q) begin
        base_q <= data_q[7:3];
        mask_q <= irg_pkg::MASK_RST;
        init_q <= 1'b1;
      end else if (wr_end) begin
        mask_q <= data_q;
      end
      if (rd_act && !sel_n_q) begin
        rdata_q <= rsel_q ? mask_q : pend_q;
      end
    end
  end

  // requests captured on rising edges only; set wins over clear
  assign req_now = {rs_q.video, ~rs_q.keyboard_n, rs_q[5:0]};
  assign req_prev = {rp_q.video, ~rp_q.keyboard_n, rp_q[5:0]};
  assign req_rise = req_now & ~req_prev;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pend_q <= '0;
    end else if (ce_i) begin
      pend_q <= (pend_q & ~ack_clr) | req_rise;
    end
  end

  // fixed priority: input 0 highest, so lowest set index wins
  assign active = pend_q & ~mask_q;
  always_comb begin
    pick_idx = 3'h0;
    pick_any = 1'b0;
    for (int i = irg_pkg::NUM_REQ - 1; i >= 0; i--) begin
      if (active[i]) begin
        pick_idx = 3'(i);
        pick_any = 1'b1;
      end
    end
  end
  assign ack_clr = (ack_q == irg_pkg::ACK_IDLE && interrupt_acknowledge_n_fall && pick_any)
                   ? (8'h01 << pick_idx) : 8'h00;

  // acknowledge sequence: first edge claims, second drives the type
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= irg_pkg::ACK_IDLE;
      sel_idx_q <= 3'h0;
      type_q <= irg_pkg::BYTE_RST;
      drive_q <= 1'b0;
    end else if (ce_i) begin
      case (ack_q)
        irg_pkg::ACK_IDLE: begin
          if (interrupt_acknowledge_n_fall) begin
            sel_idx_q <= pick_idx;
            ack_q <= irg_pkg::ACK_FIRST;
          end
        end
        irg_pkg::ACK_FIRST: begin
          if (interrupt_acknowledge_n_fall) begin
            type_q <= {base_q, sel_idx_q};
            drive_q <= 1'b1;
            ack_q <= irg_pkg::ACK_SECOND;
          end
        end
        irg_pkg::ACK_SECOND: begin
          if (interrupt_acknowledge_n_rise) begin
            drive_q <= 1'b0;
            ack_q <= irg_pkg::ACK_IDLE;
          end
        end
        default: begin
          drive_q <= 1'b0;
          ack_q <= irg_pkg::ACK_IDLE;
        end
      endcase
    end
  end

  // interrupt output held low through acknowledge so one request is one irq
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_q <= 1'b0;
    end else if (ce_i) begin
      irq_q <= pick_any & init_q & (ack_q == irg_pkg::ACK_IDLE)
               & ~interrupt_acknowledge_n_fall;
    end
  end

  assign controller_select_n_o = sel_n_q;
  assign ctrl_write_strobe_n_o = wr_n_q;
  assign ctrl_read_strobe_n_o = rd_n_q;
  assign io_latch_enable_n_o = iol_n_q;
  assign data_latch_strobe_o = dls_q;
  assign register_select_bit_o = rsel_q;
  assign master_slave_select_o = msel_q;
  assign controller_data_o = data_q;
  assign read_data_o = rdata_q;
  assign processor_irq_input_o = irq_q;
  assign type_byte_o = type_q;
  assign type_byte_drive_o = drive_q;
  assign pending_request_register_o = pend_q;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sel_decode_a: assert property (ce_i |=>
    (sel_n_q == !$past(win_hit && qual2_q)))
    else $error("select does not follow window decode");
  stage_one_a: assert property (ce_i && !stage1_en |=> sel_n_q)
    else $error("select active outside first stage");
  qual_set_a: assert property (ce_i && ale_fall &&
    (dec_y0 || dec_y1) |=> qual1_q)
    else $error("qualifier not set at ale trailing edge");
  write_strobe_a: assert property (ce_i && !wr_n_q |->
    $past(!h.wr_n && qual1_q))
    else $error("write strobe without write and qualifier");
  read_strobe_a: assert property (ce_i && !h.rd_n && qual1_q
    |=> !rd_n_q)
    else $error("read strobe missing");
  latch_enable_a: assert property (ce_i && io_latch_act |=> !iol_n_q)
    else $error("latch enable missing");
  edge_pend_a: assert property (ce_i && req_rise[3]
    |=> pend_q[3])
    else $error("rising request not captured");
  ack_clear_a: assert property (ce_i && !h.interrupt_acknowledge_n_n |=> !qual2_q)
    else $error("second qualifier survives acknowledge");
  prio_pick_a: assert property (ce_i && ack_q == irg_pkg::ACK_IDLE
    && interrupt_acknowledge_n_fall |=> sel_idx_q == $past(pick_idx))
    else $error("wrong priority chosen");
  type_byte_a: assert property (ce_i && ack_q == irg_pkg::ACK_FIRST
    && interrupt_acknowledge_n_fall |=> drive_q && type_q[2:0] == sel_idx_q)
    else $error("type byte not driven on second acknowledge");
endmodule : irg_glue

// *** hdl/irg_pkg.sv ***
// constants and carrier types for the interrupt request glue
package irg_pkg;
  // host address decode
  localparam int unsigned ADDR_W = 20;
  localparam logic [2:0] STAGE1_TOP = 3'h7;
  localparam logic [1:0] STAGE2_Y0 = 2'h0;
  localparam logic [1:0] STAGE2_Y1 = 2'h1;
  localparam logic [1:0] LOW_SEL_BITS = 2'h0;
  localparam logic [18:0] CTRL_WIN_WORD = 19'h70000;
  // request inputs
  localparam int unsigned NUM_REQ = 8;
  localparam int unsigned NUM_PAR = 7;
  // values after reset
  localparam logic [7:0] MASK_RST = 8'h00;
  localparam logic [4:0] BASE_RST = 5'h00;
  localparam logic [7:0] BYTE_RST = 8'h00;
  // pin idle levels: host strobes and acknowledge high
  localparam logic [ADDR_W+14:0] HOST_IDLE = 35'h000001c00;
  // disk sync and keyboard lines idle high, the rest low
  localparam logic [NUM_REQ-1:0] REQ_IDLE = 8'h41;

  // host side pins, sampled together
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic io_mem;
    logic ale;
    logic wr_n;
    logic rd_n;
    logic interrupt_acknowledge_n_n;
    logic phase2;
    logic tap_b;
    logic [7:0] bd;
  } irg_host_type;

  // peripheral request lines in input order 7..0
  typedef struct packed {
    logic video;
    logic keyboard_n;
    logic exp5;
    logic exp4;
    logic parallel;
    logic timer;
    logic serial_a;
    logic disk_sync;
  } irg_req_type;

  // acknowledge sequence, gray along idle, first, second
  typedef enum logic [1:0] {
    ACK_IDLE = 2'b00,
    ACK_FIRST = 2'b01,
    ACK_SECOND = 2'b11
  } irg_ack_type;
endpackage : irg_pkg

// *** verif/irg_host_model.sv ***
// host processor model: bus cycles and acknowledge pulses
`timescale 1ns/1ps
module irg_host_model (
  // clock
  input wire logic clk_i,
  // interrupt from the glue
  input wire logic irq_i,
  // host pins
  output irg_pkg::irg_host_type host_o
);
  // idle bus: strobes and acknowledge high
  initial begin
    host_o = '0;
    host_o.wr_n = 1'b1;
    host_o.rd_n = 1'b1;
    host_o.interrupt_acknowledge_n_n = 1'b1;
  end

  task automatic step(input int n);
    repeat (n) @(posedge clk_i);
  endtask : step

  // address, latch and phase 2, then the strobe is left low for the caller
  task automatic start(input logic [19:0] a, input logic io,
      input logic wr, input logic [7:0] d);
    host_o.addr <= a;
    host_o.io_mem <= io;
    host_o.bd <= d;
    host_o.ale <= 1'b1;
    step(4);
    host_o.ale <= 1'b0;
    step(4);
    host_o.phase2 <= 1'b1;
    host_o.tap_b <= 1'b1;
    step(4);
    if (wr)
      host_o.wr_n <= 1'b0;
    else
      host_o.rd_n <= 1'b0;
    step(5);
  endtask : start

  // release strobes; the dropped bus shows scrambled values, not old ones
  task automatic stop;
    host_o.wr_n <= 1'b1;
    host_o.rd_n <= 1'b1;
    step(5);
    host_o.phase2 <= 1'b0;
    host_o.tap_b <= 1'b0;
    host_o.addr <= ~host_o.addr;
    host_o.bd <= ~host_o.bd;
    step(4);
  endtask : stop

  // interrupts enabled: wait for the line, bounded so a dead line shows
  task automatic wait_irq;
    for (int i = 0; i < 20 && !irq_i; i++)
      step(1);
  endtask : wait_irq

  // one half of an acknowledge pulse
  task automatic ack(input logic lvl);
    host_o.interrupt_acknowledge_n_n <= lvl;
    step(5);
  endtask : ack
endmodule : irg_host_model

// *** verif/tb_top.sv ***
// self-checking bench for the interrupt request glue
`timescale 1ns/1ps
module tb_top;
  logic clk_i;
  logic rst_i;
  logic ce;
  logic irq, sel_n, wrs_n, rds_n, lat_n, dls, rsel, msel, tdrv;
  logic [7:0] cdat, rdat, tbyte, pend;
  logic [6:0] par;
  irg_pkg::irg_host_type host;
  irg_pkg::irg_req_type req;
  int err_count;
  int tests_run;
  int cycles;

  irg_host_model host_m (.clk_i(clk_i), .irq_i(irq), .host_o(host));

  irg_glue dut (
    .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce),
    .addr_i(host.addr), .io_mem_i(host.io_mem), .ale_i(host.ale),
    .wr_n_i(host.wr_n), .rd_n_i(host.rd_n),
    .interrupt_acknowledge_n_i(host.interrupt_acknowledge_n_n), .phase2_i(host.phase2),
    .divider_tap_b_i(host.tap_b), .buffered_data_i(host.bd),
    .disk_sync_request_i(req.disk_sync), .serial_request_a_i(req.serial_a),
    .timer_request_i(req.timer), .parallel_request_i(par),
    .expansion4_request_i(req.exp4), .expansion5_request_i(req.exp5),
    .keyboard_request_n_i(req.keyboard_n), .video_request_i(req.video),
    .controller_select_n_o(sel_n), .ctrl_write_strobe_n_o(wrs_n),
    .ctrl_read_strobe_n_o(rds_n), .io_latch_enable_n_o(lat_n),
    .data_latch_strobe_o(dls), .register_select_bit_o(rsel),
    .master_slave_select_o(msel), .controller_data_o(cdat),
    .read_data_o(rdat), .processor_irq_input_o(irq),
    .type_byte_o(tbyte), .type_byte_drive_o(tdrv),
    .pending_request_register_o(pend)
  );

  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end

  // hang guard: the sequence needs well under a thousand cycles
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 3000) begin
      err_count++;
      conclude();
    end
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic conclude;
    $display("compares %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : conclude

  // drive one plain request line by its input number
  task automatic set_req(input int n, input logic v);
    case (n)
      1: req.serial_a <= v;
      2: req.timer <= v;
      4: req.exp4 <= v;
      5: req.exp5 <= v;
      default: ;
    endcase
  endtask : set_req

  // acknowledge pair; type byte is looked at inside the second pulse
  task automatic ack_pair(input logic [7:0] ty);
    host_m.ack(1'b0);
    check(irq, 1'b0);
    host_m.ack(1'b1);
    host_m.ack(1'b0);
    check(tdrv, 1'b1);
    check(tbyte, ty);
    check(sel_n, 1'b1);
    host_m.ack(1'b1);
    check(tdrv, 1'b0);
  endtask : ack_pair

  // boot programming: base 0x48, mask only input 7, read the mask back
  task automatic t_init;
    check(sel_n, 1'b1);
    check(msel, 1'b1);
    host_m.start(20'he0000, 1'b0, 1'b1, 8'h48);
    check(sel_n, 1'b0);
    check(wrs_n, 1'b0);
    check(rsel, 1'b0);
    check(lat_n, 1'b0);
    check(dls, 1'b1);
    check(cdat, 8'h48);
    host_m.stop();
    host_m.start(20'he0001, 1'b0, 1'b1, 8'h80);
    check(rsel, 1'b1);
    host_m.stop();
    host_m.start(20'he0001, 1'b0, 1'b0, 8'h00);
    check(rds_n, 1'b0);
    check(wrs_n, 1'b1);
    host_m.stop();
    check(rdat, 8'h80);
    $display("test init done");
  endtask : t_init

  // near misses: no select; io space never sets the qualifier
  task automatic t_window;
    logic [19:0] a [3] = '{20'he0002, 20'he0040, 20'he0000};
    logic io [3] = '{1'b0, 1'b0, 1'b1};
    for (int i = 0; i < 3; i++) begin
      host_m.start(a[i], io[i], 1'b1, 8'h07);
      check(sel_n, 1'b1);
      check(wrs_n, io[i]);
      host_m.stop();
    end
    $display("test window done");
  endtask : t_window

  // keyboard and adapters together: input 3 served before input 6
  task automatic t_prio;
    req.keyboard_n <= 1'b0;
    par <= 7'h10;
    host_m.step(6);
    check(pend, 8'h48);
    host_m.wait_irq();
    check(irq, 1'b1);
    ack_pair(8'h4b);
    check(pend, 8'h40);
    host_m.wait_irq();
    ack_pair(8'h4e);
    host_m.step(6);
    check(pend, 8'h00);
    check(irq, 1'b0);
    $display("test priority done");
  endtask : t_prio

  // disk pulse, each remaining input, and a masked video request
  task automatic t_sources;
    req.keyboard_n <= 1'b1;
    par <= 7'h00;
    req.disk_sync <= 1'b0;
    host_m.step(4);
    req.disk_sync <= 1'b1;
    req.video <= 1'b1;
    host_m.step(6);
    check(pend, 8'h81);
    host_m.wait_irq();
    ack_pair(8'h48);
    for (int i = 1; i < 6; i++) begin
      if (i != 3) begin
        set_req(i, 1'b1);
        host_m.step(6);
        host_m.wait_irq();
        ack_pair(8'h48 | 8'(i));
        set_req(i, 1'b0);
      end
    end
    host_m.step(6);
    check(pend, 8'h80);
    check(irq, 1'b0);
    $display("test sources done");
  endtask : t_sources

  // enable low freezes the edge detectors; the edge lands after release
  task automatic t_freeze;
    ce <= 1'b0;
    set_req(5, 1'b1);
    host_m.step(6);
    check(pend, 8'h80);
    check(irq, 1'b0);
    ce <= 1'b1;
    host_m.step(6);
    check(pend, 8'ha0);
    host_m.wait_irq();
    ack_pair(8'h4d);
    set_req(5, 1'b0);
    host_m.step(6);
    check(pend, 8'h80);
    $display("test freeze done");
  endtask : t_freeze

  initial begin
    rst_i = 1'b1;
    ce = 1'b1;
    par = 7'h00;
    req = '0;
    req.disk_sync = 1'b1;
    req.keyboard_n = 1'b1;
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    host_m.step(3);
    t_init();
    t_window();
    t_prio();
    t_sources();
    t_freeze();
    conclude();
  end
endmodule : tb_top
